// ### hw/dic_input_cond.sv
// control terminal input conditioning for a motor drive
`timescale 1ns/1ps
module dic_input_cond
  import dic_pkg::*;
#(
  parameter int P_FILT_TICK_CYC = FILT_TICK_CYC,
  parameter int P_GATE_TICK_CYC = GATE_TICK_CYC,
  parameter int P_UPDOWN_CYC = UPDOWN_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // three-wire run command
  input wire logic three_wire_mode,
  input wire logic [2:0] enable_terminal,
  input wire logic forward_run_in,
  input wire logic direction_select_in,
  output logic run_cmd,
  output logic run_reverse,
  // up/down frequency
  input wire logic freq_up,
  input wire logic freq_down,
  input wire logic freq_load,
  input wire logic [23:0] freq_preset,
  input wire logic [23:0] freq_limit,
  input wire logic [15:0] updown_rate_param,
  input wire logic [1:0] freq_decimal_places,
  output logic [23:0] freq_set,
  // analog inputs, 0.01 V or 0.01 mA units
  input wire logic signed [15:0] analog_in_first,
  input wire logic signed [15:0] analog_in_second,
  input wire logic [1:0] analog_current_mode,
  input wire logic [11:0] curve_select_param,
  input wire logic [7:0] below_min_select_param,
  // curves 1 to 3, entry 3 is the pulse curve
  input wire logic signed [15:0] curve_min_in [0:3],
  input wire logic signed [15:0] curve_max_in [0:3],
  input wire logic signed [15:0] curve_min_set [0:3],
  input wire logic signed [15:0] curve_max_set [0:3],
  // filter time constants, 0.01 s units: first, second, pulse
  input wire logic [10:0] filter_time [0:2],
  output logic signed [15:0] analog_set_first,
  output logic signed [15:0] analog_set_second,
  output logic signed [15:0] pulse_set,
  output logic [15:0] pulse_freq,
  // digital inputs, high when closed to common
  input wire logic [3:0] digital_in_closed,
  input wire logic pulse_capable_input,
  input wire logic [4:0] input_polarity_param,
  input wire logic [15:0] di_delay [0:2],
  output logic [4:0] di_valid
);
  dic_run_t run_state;
  logic [31:0] filt_cnt;
  logic filt_tick;
  logic [31:0] gate_cnt;
  logic gate_tick;
  logic [31:0] ud_frac;
  logic [32:0] ud_sum;
  logic [19:0] rate_step;
  logic [4:0] closed_all;
  logic [4:0] raw_valid;
  logic pulse_prev;
  logic [15:0] edge_cnt;
  logic enable_ok;
  logic signed [15:0] ch_in [0:2];
  logic signed [15:0] ch_out [0:2];

  function automatic logic [1:0] curve_index(input logic [3:0] digit);
    unique case (digit)
      4'h2: curve_index = 2'h1;
      4'h3: curve_index = 2'h2;
      default: curve_index = 2'h0;
    endcase
  endfunction

  // filter and gate ticks
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      filt_cnt <= '0;
      filt_tick <= 1'b0;
    end else begin
      filt_tick <= (filt_cnt == 32'(P_FILT_TICK_CYC - 1));
      filt_cnt <= (filt_cnt == 32'(P_FILT_TICK_CYC - 1)) ? '0 : filt_cnt + 32'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gate_cnt <= '0;
      gate_tick <= 1'b0;
    end else begin
      gate_tick <= (gate_cnt == 32'(P_GATE_TICK_CYC - 1));
      gate_cnt <= (gate_cnt == 32'(P_GATE_TICK_CYC - 1)) ? '0 : gate_cnt + 32'h1;
    end
  end

  // enable taken from the terminal given the three-wire function
  assign enable_ok = (enable_terminal < 3'(NUM_DI)) ? di_valid[enable_terminal] : 1'b0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      run_state <= RS_STOP;
      run_reverse <= 1'b0;
    end else begin
      unique case (run_state)
        RS_STOP: begin
          if (three_wire_mode && enable_ok && forward_run_in) begin
            run_state <= RS_RUN;
          end
        end
        RS_RUN: begin
          if (!three_wire_mode || !enable_ok) begin
            run_state <= RS_STOP;
          end
        end
      endcase
      run_reverse <= direction_select_in;
    end
  end
  assign run_cmd = (run_state == RS_RUN);

  assign rate_step = (freq_decimal_places == DEC_ONE) ?
                     20'(updown_rate_param) * 20'(RATE_SCALE_ONE_DEC) : 20'(updown_rate_param);
  assign ud_sum = 33'(ud_frac) + 33'(rate_step);

  // up/down stepping, one 0.01 Hz step per accumulated period
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ud_frac <= '0;
      freq_set <= FREQ_RST;
    end else if (freq_load) begin
      ud_frac <= '0;
      freq_set <= freq_preset;
    end else if (freq_up ^ freq_down) begin
      if (ud_sum >= 33'(P_UPDOWN_CYC)) begin
        ud_frac <= 32'(ud_sum - 33'(P_UPDOWN_CYC));
        if (freq_up && freq_set < freq_limit) begin
          freq_set <= freq_set + 24'h1;
        end else if (freq_down && freq_set != 24'h0) begin
          freq_set <= freq_set - 24'h1;
        end
      end else begin
        ud_frac <= ud_sum[31:0];
      end
    end else begin
      ud_frac <= '0;
    end
  end

  // pulse counting on the fifth input only, 10 Hz per count per gate
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pulse_prev <= 1'b0;
      edge_cnt <= '0;
      pulse_freq <= '0;
    end else begin
      pulse_prev <= pulse_capable_input;
      if (gate_tick) begin
        pulse_freq <= edge_cnt;
        edge_cnt <= {15'h0, pulse_capable_input && !pulse_prev};
      end else if (pulse_capable_input && !pulse_prev && edge_cnt != 16'hFFFF) begin
        edge_cnt <= edge_cnt + 16'h1;
      end
    end
  end

  assign ch_in[0] = analog_current_mode[0] ?
                    (analog_in_first >>> CUR_TO_VOLT_SHIFT) : analog_in_first;
  assign ch_in[1] = analog_current_mode[1] ?
                    (analog_in_second >>> CUR_TO_VOLT_SHIFT) : analog_in_second;
  assign ch_in[2] = pulse_freq;

  // per channel filter and curve
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic signed [23:0] acc;
    logic signed [23:0] diff;
    dic_curve_if cif ();
    assign diff = {ch_in[c], FILT_FRAC'(0)} - acc;
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        acc <= '0;
      end else if (filter_time[c] == 11'h0) begin
        acc <= {ch_in[c], FILT_FRAC'(0)};
      end else if (filt_tick) begin
        acc <= acc + diff / $signed({13'h0, filter_time[c]});
      end
    end
    assign cif.x = acc[23:FILT_FRAC];
    if (c == 2) begin : g_pulse
      assign cif.min_in = curve_min_in[PULSE_CURVE];
      assign cif.max_in = curve_max_in[PULSE_CURVE];
      assign cif.min_set = curve_min_set[PULSE_CURVE];
      assign cif.max_set = curve_max_set[PULSE_CURVE];
      assign cif.below_zero = 1'b0;
    end else begin : g_ai
      logic [1:0] idx;
      assign idx = curve_index(curve_select_param[(c == 0 ? DIGIT_AI1_LSB : DIGIT_AI2_LSB) +: 4]);
      assign cif.min_in = curve_min_in[idx];
      assign cif.max_in = curve_max_in[idx];
      assign cif.min_set = curve_min_set[idx];
      assign cif.max_set = curve_max_set[idx];
      assign cif.below_zero =
        below_min_select_param[(c == 0 ? DIGIT_AI1_LSB : DIGIT_AI2_LSB)];
    end
    dic_curve_map u_map (
      .core_clk(core_clk),
      .rst(rst),
      .bus(cif.map)
    );
    assign ch_out[c] = cif.set_out;
  end

  assign analog_set_first = ch_out[0];
  assign analog_set_second = ch_out[1];
  assign pulse_set = ch_out[2];

  assign closed_all = {pulse_capable_input, digital_in_closed};
  assign raw_valid = closed_all ^ input_polarity_param;

  // delay on the first three terminals only, the last two registered without delay
  for (genvar i = 0; i < NUM_DI; i++) begin : g_di
    logic valid_q;
    if (i < NUM_DELAYED_DI) begin : g_dly
      logic [15:0] cnt;
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          valid_q <= 1'b0;
          cnt <= '0;
        end else if (raw_valid[i] == valid_q) begin
          cnt <= '0;
        end else if (di_delay[i] == 16'h0 || (gate_tick && cnt == di_delay[i] - 16'h1)) begin
          valid_q <= raw_valid[i];
          cnt <= '0;
        end else if (gate_tick) begin
          cnt <= cnt + 16'h1;
        end
      end
    end else begin : g_nodly
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          valid_q <= 1'b0;
        end else begin
          valid_q <= raw_valid[i];
        end
      end
    end
    assign di_valid[i] = valid_q;
  end

  AST_START_RUN: assert property (@(posedge core_clk) disable iff (rst)
    three_wire_mode && enable_ok && forward_run_in |=> run_cmd)
    else $error("run not started on forward run");

  AST_DIRECTION: assert property (@(posedge core_clk) disable iff (rst)
    run_cmd ##1 run_cmd |-> run_reverse == $past(direction_select_in))
    else $error("direction not following select input");

  AST_STOP_DISABLE: assert property (@(posedge core_clk) disable iff (rst)
    three_wire_mode && !enable_ok |=> !run_cmd)
    else $error("drive not stopped when enable dropped");

  AST_UPDOWN_STEP: assert property (@(posedge core_clk) disable iff (rst)
    !freq_load |=> (freq_set == $past(freq_set)) || (freq_set == $past(freq_set) + 24'h1)
                   || (freq_set == $past(freq_set) - 24'h1))
    else $error("frequency moved by more than one step");

  AST_UPDOWN_IDLE: assert property (@(posedge core_clk) disable iff (rst)
    !freq_load && !(freq_up ^ freq_down) |=> $stable(freq_set))
    else $error("frequency moved without up or down");

  AST_LOAD: assert property (@(posedge core_clk) disable iff (rst)
    freq_load |=> freq_set == $past(freq_preset))
    else $error("preset not loaded");

  AST_NO_DELAY: assert property (@(posedge core_clk) disable iff (rst)
    ##1 di_valid[4:3] == $past(closed_all[4:3] ^ input_polarity_param[4:3]))
    else $error("undelayed terminal not following its pin");

  AST_DELAY_TIMING: assert property (@(posedge core_clk) disable iff (rst)
    $changed(di_valid[0]) |-> $past(gate_tick) || $past(di_delay[0] == 16'h0))
    else $error("delayed terminal changed off a gate tick");

  AST_POLARITY: assert property (@(posedge core_clk) disable iff (rst)
    closed_all[3] && !input_polarity_param[3] |=> di_valid[3])
    else $error("active-high closed terminal not valid");

  AST_POLARITY_LOW: assert property (@(posedge core_clk) disable iff (rst)
    closed_all[4] && input_polarity_param[4] |=> !di_valid[4])
    else $error("active-low closed terminal not invalid");
endmodule // dic_input_cond

// ### inc/dic_pkg.sv
// shared constants and types for the drive input terminal conditioning block
package dic_pkg;
  // clock rate
  localparam int CLK_HZ = 100_000_000;
  // filter update period, milliseconds, and its cycle count
  localparam int FILT_TICK_MS = 10;
  localparam int FILT_TICK_CYC = CLK_HZ / 1000 * FILT_TICK_MS;
  // delay and pulse gate period, milliseconds, and its cycle count
  localparam int GATE_TICK_MS = 100;
  localparam int GATE_TICK_CYC = CLK_HZ / 1000 * GATE_TICK_MS;
  // up/down rate period, seconds, and its cycle count
  localparam int UPDOWN_PERIOD_S = 1;
  localparam int UPDOWN_CYC = CLK_HZ * UPDOWN_PERIOD_S;
  // rate scale when the frequency has one decimal place
  localparam logic [1:0] DEC_ONE = 2'h1;
  localparam logic [3:0] RATE_SCALE_ONE_DEC = 4'hA;
  // current mode: 1 mA per 0.5 V, a halving of the 0.01 unit value
  localparam int CUR_TO_VOLT_SHIFT = 1;
  // digit positions in the selection parameters
  localparam int DIGIT_AI1_LSB = 0;
  localparam int DIGIT_AI2_LSB = 4;
  // terminal counts
  localparam int NUM_DI = 5;
  localparam int NUM_DELAYED_DI = 3;
  localparam int PULSE_DI = 4;
  localparam int NUM_CH = 3;
  localparam int PULSE_CURVE = 3;
  // filter fraction bits
  localparam int FILT_FRAC = 8;
  // documented configuration defaults
  localparam logic [11:0] CURVE_SEL_DEFAULT = 12'h321;
  localparam logic signed [15:0] CURVE12_MAX_IN_DEFAULT = 16'sh03E8;
  localparam logic signed [15:0] CURVE3_MIN_IN_DEFAULT = -16'sh03E8;
  localparam logic signed [15:0] CURVE3_MIN_SET_DEFAULT = -16'sh2710;
  localparam logic [10:0] FILT_TAU_DEFAULT = 11'h00A;
  localparam logic signed [15:0] PULSE_MAX_DEFAULT = 16'sh1388;
  // reset values
  localparam logic [23:0] FREQ_RST = 24'h000000;
  localparam logic signed [15:0] SET_RST = 16'sh0000;
  // three-wire run state
  typedef enum logic {RS_STOP, RS_RUN} dic_run_t;
endpackage

// ### inc/dic_curve_if.sv
// curve mapping signals between the main block and the curve mapper
`timescale 1ns/1ps
interface dic_curve_if;
  logic signed [15:0] x;
  logic signed [15:0] min_in;
  logic signed [15:0] max_in;
  logic signed [15:0] min_set;
  logic signed [15:0] max_set;
  logic below_zero;
  logic signed [15:0] set_out;
  modport cfg (output x, output min_in, output max_in, output min_set, output max_set,
               output below_zero, input set_out);
  modport map (input x, input min_in, input max_in, input min_set, input max_set,
               input below_zero, output set_out);
endinterface

// ### hw/dic_curve_map.sv
// two-point curve mapper with clamping and below-minimum handling
`timescale 1ns/1ps
module dic_curve_map
  import dic_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // curve
  dic_curve_if.map bus
);
  logic signed [16:0] span_in;
  logic signed [16:0] span_set;
  logic signed [16:0] offs;
  logic signed [33:0] prod;
  logic signed [33:0] quot;
  logic signed [15:0] next_set;

  assign span_in = 17'(bus.max_in) - 17'(bus.min_in);
  assign span_set = 17'(bus.max_set) - 17'(bus.min_set);
  assign offs = 17'(bus.x) - 17'(bus.min_in);
  assign prod = 34'(offs) * 34'(span_set);
  assign quot = (span_in > 17'sh00000) ? prod / 34'(span_in) : 34'sh0;

  always_comb begin
    if (bus.x < bus.min_in) begin
      next_set = bus.below_zero ? SET_RST : bus.min_set;
    end else if (bus.x >= bus.max_in) begin
      next_set = bus.max_set;
    end else begin
      next_set = 16'(34'(bus.min_set) + quot);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus.set_out <= SET_RST;
    end else begin
      bus.set_out <= next_set;
    end
  end

  AST_BELOW_ZERO: assert property (@(posedge core_clk) disable iff (rst)
    (bus.x < bus.min_in) && bus.below_zero |=> bus.set_out == 16'sh0000)
    else $error("below-minimum input did not give zero");

  AST_CLAMP_MAX: assert property (@(posedge core_clk) disable iff (rst)
    (bus.x >= bus.max_in) && (bus.x >= bus.min_in) |=> bus.set_out == $past(bus.max_set))
    else $error("input above maximum not clamped");
endmodule // dic_curve_map

// ### tb/dic_src_model.sv
// pulse source standing in for the external pulse generator
`timescale 1ns/1ps
module dic_src_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // pulse control
  input wire logic pulse_en,
  input wire logic [7:0] period,
  // pulse pin, wired to the fifth terminal
  output logic pulse_out
);
  logic [7:0] cnt;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= 8'h00;
      pulse_out <= 1'b0;
    end else if (!pulse_en) begin
      cnt <= 8'h00;
      pulse_out <= 1'b0;
    end else begin
      cnt <= (cnt + 8'h01 >= period) ? 8'h00 : cnt + 8'h01;
      pulse_out <= (cnt < (period >> 1));
    end
  end
endmodule // dic_src_model

// ### tb/dic_input_cond_tb.sv
// self-checking bench for the input conditioning block
`timescale 1ns/1ps
`define CHK(e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %0d exp %0d", $time, g, e); end end
module dic_input_cond_tb
  import dic_pkg::*;
;
  localparam int FT = 10;
  localparam int GT = 20;
  localparam int UC = 100;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic three_wire_mode = 1'b0, forward_run_in = 1'b0, direction_select_in = 1'b0;
  logic run_cmd, run_reverse, pulse_pin;
  logic [2:0] enable_terminal = 3'h7;
  logic freq_up = 1'b0, freq_down = 1'b0, freq_load = 1'b0, pulse_en = 1'b0;
  logic [23:0] freq_preset = 24'h000000, freq_limit = 24'h0003F8, freq_set;
  logic [15:0] updown_rate_param = 16'h0000, pulse_freq;
  logic [1:0] freq_decimal_places = 2'h2, analog_current_mode = 2'h0;
  logic signed [15:0] ain1 = 16'sh0000, ain2 = 16'sh0000, aset1, aset2, pulse_set;
  logic [11:0] curve_select_param = CURVE_SEL_DEFAULT;
  logic [7:0] below_min_select_param = 8'h00;
  logic signed [15:0] cmin [0:3] = '{16'sh0000, 16'sh00C8, -16'sh03E8, 16'sh0000};
  logic signed [15:0] cmax [0:3] = '{16'sh03E8, 16'sh0320, 16'sh03E8, 16'sh01F4};
  logic signed [15:0] smin [0:3] = '{16'sh0000, -16'sh1388, -16'sh2710, 16'sh0000};
  logic signed [15:0] smax [0:3] = '{16'sh2710, 16'sh1388, 16'sh2710, 16'sh2710};
  logic [10:0] ftime [0:2] = '{11'h000, 11'h000, 11'h000};
  logic [15:0] ddelay [0:2] = '{16'h0000, 16'h0000, 16'h0000};
  logic [3:0] closed = 4'h0;
  logic [4:0] pol = 5'h00, di_valid;
  int fails = 0;
  int compares = 0;
  int cycles = 0;

  always #5 core_clk = ~core_clk;

  dic_input_cond #(.P_FILT_TICK_CYC(FT), .P_GATE_TICK_CYC(GT), .P_UPDOWN_CYC(UC)) DUT (
    .core_clk(core_clk), .rst(rst), .three_wire_mode(three_wire_mode),
    .enable_terminal(enable_terminal), .forward_run_in(forward_run_in),
    .direction_select_in(direction_select_in), .run_cmd(run_cmd), .run_reverse(run_reverse),
    .freq_up(freq_up), .freq_down(freq_down), .freq_load(freq_load),
    .freq_preset(freq_preset), .freq_limit(freq_limit), .updown_rate_param(updown_rate_param),
    .freq_decimal_places(freq_decimal_places), .freq_set(freq_set),
    .analog_in_first(ain1), .analog_in_second(ain2), .analog_current_mode(analog_current_mode),
    .curve_select_param(curve_select_param), .below_min_select_param(below_min_select_param),
    .curve_min_in(cmin), .curve_max_in(cmax), .curve_min_set(smin), .curve_max_set(smax),
    .filter_time(ftime), .analog_set_first(aset1), .analog_set_second(aset2),
    .pulse_set(pulse_set), .pulse_freq(pulse_freq), .digital_in_closed(closed),
    .pulse_capable_input(pulse_pin), .input_polarity_param(pol), .di_delay(ddelay),
    .di_valid(di_valid));

  dic_src_model src (.core_clk(core_clk), .rst(rst), .pulse_en(pulse_en), .period(8'h04),
    .pulse_out(pulse_pin));

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // reference curve: current halving, clamp, below-minimum choice, interpolation
  function automatic int curve(input int x, input int c, input bit cur, input bit zb);
    int v;
    v = cur ? (x >>> 1) : x;
    if (v > cmax[c]) v = cmax[c];
    if (v < cmin[c]) return zb ? 0 : smin[c];
    return smin[c] + (v - cmin[c]) * (smax[c] - smin[c]) / (cmax[c] - cmin[c]);
  endfunction

  task automatic results();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      results();
    end
  end

  initial begin
    int n, x1, x2, c1, c2, e;
    logic [3:0] cl;
    logic [4:0] pl;
    logic [1:0] m, z;
    n = $urandom(6);
    cyc(8);
    rst <= 1'b0;
    cyc(2);
    repeat (8) begin
      cl = 4'($urandom);
      pl = 5'($urandom);
      closed <= cl;
      pol <= pl;
      cyc(4);
      `CHK(cl ^ pl[3:0], di_valid[3:0])
      `CHK(pl[4], di_valid[4])
    end
    ddelay[0] <= 16'h0003;
    pol <= 5'h00;
    closed <= 4'h0;
    cyc(80);
    closed <= 4'h9;
    cyc(5);
    `CHK(1'b1, di_valid[3])
    cyc(33);
    `CHK(1'b0, di_valid[0])
    cyc(32);
    `CHK(1'b1, di_valid[0])
    // terminal 4 given the three-wire function
    enable_terminal <= 3'h3;
    closed <= 4'h8;
    forward_run_in <= 1'b1;
    cyc(4);
    `CHK(1'b0, run_cmd)
    forward_run_in <= 1'b0;
    closed <= 4'h0;
    three_wire_mode <= 1'b1;
    cyc(2);
    forward_run_in <= 1'b1;
    cyc(4);
    `CHK(1'b0, run_cmd)
    closed <= 4'h8;
    cyc(4);
    `CHK(1'b1, run_cmd)
    for (n = 0; n < 2; n++) begin
      direction_select_in <= n[0];
      cyc(3);
      `CHK(n[0], run_reverse)
    end
    forward_run_in <= 1'b0;
    cyc(3);
    `CHK(1'b1, run_cmd)
    closed <= 4'h0;
    cyc(4);
    `CHK(1'b0, run_cmd)
    three_wire_mode <= 1'b0;
    for (n = 0; n < 2; n++) begin
      freq_decimal_places <= n ? DEC_ONE : 2'h2;
      updown_rate_param <= n ? 16'h0002 : 16'h0014;
      freq_preset <= 24'h0003E8;
      freq_load <= 1'b1;
      cyc(1);
      freq_load <= 1'b0;
      freq_up <= 1'b1;
      cyc(57);
      freq_up <= 1'b0;
      cyc(3);
      e = 1000 + 57 * (n ? 2 * 10 : 20) / UC;
      `CHK(24'(e), freq_set)
    end
    updown_rate_param <= 16'h0064;
    freq_up <= 1'b1;
    cyc(30);
    `CHK(24'h0003F8, freq_set)
    freq_load <= 1'b1;
    freq_preset <= 24'h000005;
    cyc(2);
    `CHK(24'h000005, freq_set)
    freq_load <= 1'b0;
    freq_up <= 1'b0;
    freq_down <= 1'b1;
    cyc(30);
    `CHK(24'h000000, freq_set)
    freq_down <= 1'b0;
    repeat (60) begin
      c1 = $urandom_range(3, 1);
      c2 = $urandom_range(3, 1);
      x1 = $urandom_range(2400) - 1200;
      x2 = $urandom_range(2400) - 1200;
      m = 2'($urandom);
      z = 2'($urandom);
      ain1 <= 16'(x1);
      ain2 <= 16'(x2);
      curve_select_param <= {4'h3, 4'(c2), 4'(c1)};
      below_min_select_param <= {3'h0, z[1], 3'h0, z[0]};
      analog_current_mode <= m;
      cyc(4);
      `CHK(16'(curve(x1, c1 - 1, m[0], z[0])), aset1)
      `CHK(16'(curve(x2, c2 - 1, m[1], z[1])), aset2)
    end
    curve_select_param <= CURVE_SEL_DEFAULT;
    analog_current_mode <= 2'h0;
    ain1 <= 16'sh0000;
    cyc(4);
    ftime[0] <= FILT_TAU_DEFAULT;
    ain1 <= 16'sh03E8;
    cyc(25);
    `CHK(1'b1, aset1 > 16'sh0000 && aset1 < 16'sh1388)
    cyc(1000);
    `CHK(1'b1, aset1 > 16'sh26F0)
    pulse_en <= 1'b1;
    cyc(100);
    `CHK(16'h0005, pulse_freq)
    `CHK(16'(curve(5, 3, 1'b0, 1'b0)), pulse_set)
    results();
  end
endmodule // dic_input_cond_tb
